// >>> pkg/wdr_pkg.sv
// Shared constants and types of the watchdog register block
package wdr_pkg;

  // Bus widths
  localparam int ADDR_W = 14;             // Byte address, covers index 12'hFFF times four
  localparam int DATA_W = 32;             // AXI4-Lite data width

  // Register indexes, byte address is four times the index
  localparam logic [11:0] IDX_CTL      = 12'hFF0;  // Control on write, cause status on read
  localparam logic [11:0] IDX_UPPER    = 12'hFF1;  // Reload bits 23:16
  localparam logic [11:0] IDX_MIDDLE   = 12'hFF2;  // Reload bits 15:8
  localparam logic [11:0] IDX_LOW      = 12'hFF3;  // Reload bits 7:0
  localparam logic [11:0] IDX_INT_STAT = 12'h100;  // Sticky event bits, write one to clear
  localparam logic [11:0] IDX_INT_MASK = 12'h101;  // Event enables onto the interrupt line

  // Reset cause flag positions in the status byte
  localparam int POS_POR     = 7;          // Power-on reset
  localparam int POS_STOP    = 6;          // Stop-mode recovery
  localparam int POS_TIMEOUT = 5;          // Watchdog timeout
  localparam int POS_PIN     = 4;          // External pin reset

  // Interrupt event positions
  localparam int INT_TIMEOUT = 0;          // Counter expired
  localparam int INT_PIN     = 1;          // External reset pin seen

  // Values after reset
  localparam logic [7:0]  CAUSE_RST  = 8'h80;      // Block reset counts as power-on
  localparam logic [23:0] RELOAD_RST = 24'h000400; // Upper 00, middle 04, low 00
  localparam logic [1:0]  INT_RST    = 2'h0;       // No events, all masked

  // Counter prescale: one tick every this many clocks
  localparam logic [7:0] TICK_DIV = 8'h04;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register selected by an address
  typedef enum logic [2:0] {
    SEL_NONE, SEL_CTL, SEL_UPPER, SEL_MIDDLE, SEL_LOW, SEL_INT_STAT, SEL_INT_MASK
  } wdr_sel_t;

endpackage : wdr_pkg

// >>> pkg/wdr_cnt_if.sv
// Link between the register front end and the countdown counter
`timescale 1ns/1ns
interface wdr_cnt_if;
  logic        tick;        // Prescaled count enable, one cycle
  logic        load;        // Refresh: copy reload value into counter
  logic [23:0] reload_val;  // Value loaded on refresh and on expiry
  logic [23:0] count;       // Present counter value
  logic        expire;      // One-cycle pulse when counter ran out

  modport ctrl (output tick, output load, output reload_val, input count, input expire);
  modport cnt  (input tick, input load, input reload_val, output count, output expire);
endinterface : wdr_cnt_if

// >>> core/wdr_counter.sv
// Watchdog 24-bit countdown counter
`timescale 1ns/1ns
module wdr_counter
  import wdr_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Front end link
  wdr_cnt_if.cnt    bus
);

  logic [23:0] count;        // Present value
  logic [23:0] next_count;
  logic        expire;       // Registered expiry pulse
  logic        next_expire;

  // Next count: refresh beats a tick so software always wins a race
  always_comb begin
    next_count  = count;
    next_expire = 1'b0;
    if (bus.load) begin
      next_count = bus.reload_val;
    end else if (bus.tick) begin
      if (count == 24'h000000) begin
        // Ran out: signal and start again from the reload value
        next_expire = 1'b1;
        next_count  = bus.reload_val;
      end else begin
        next_count = count - 24'h000001;
      end
    end
  end

  // Counter registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count  <= RELOAD_RST;
      expire <= 1'b0;
    end else begin
      count  <= next_count;
      expire <= next_expire;
    end
  end

  assign bus.count  = count;
  assign bus.expire = expire;

  a_expire_reload: assert property (@(posedge clk_in) disable iff (rst_in)
    bus.tick && !bus.load && count == 24'h000000 |=> expire && count == $past(bus.reload_val))
    else $error("counter did not expire and reload at zero");

  a_count_step: assert property (@(posedge clk_in) disable iff (rst_in)
    bus.tick && !bus.load && count != 24'h000000 |=> !expire && count == $past(count) - 24'h1)
    else $error("counter did not step down by one");

endmodule : wdr_counter

// >>> core/wdr_top.sv
// Watchdog register front end with AXI4-Lite slave
`timescale 1ns/1ns
module wdr_top
  import wdr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  // AXI4-Lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  // AXI4-Lite read data
  output logic [DATA_W-1:0]      s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  // Reset cause pins, asynchronous
  input  wire logic              stop_recovery_in,
  input  wire logic              pin_reset_in,
  // System outputs
  output logic                   wd_reset_out,
  output logic                   irq_out
);

  // Decode a byte address into a register select; used for reads and writes
  function automatic wdr_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [11:0] idx;
    idx = addr[ADDR_W-1:2];
    case (idx)
      IDX_CTL:      decode = SEL_CTL;
      IDX_UPPER:    decode = SEL_UPPER;
      IDX_MIDDLE:   decode = SEL_MIDDLE;
      IDX_LOW:      decode = SEL_LOW;
      IDX_INT_STAT: decode = SEL_INT_STAT;
      IDX_INT_MASK: decode = SEL_INT_MASK;
      default:      decode = SEL_NONE;
    endcase
  endfunction : decode

  wdr_cnt_if cnt_if ();                      // Link to the counter

  // Write channel state
  logic              aw_held;                // Write address taken, waiting
  logic              next_aw_held;
  logic [ADDR_W-1:0] aw_addr;                // Held write address
  logic [ADDR_W-1:0] next_aw_addr;
  logic              w_held;                 // Write data taken, waiting
  logic              next_w_held;
  logic [7:0]        w_data;                 // Held low byte, the only used lane
  logic [7:0]        next_w_data;
  logic              w_lane0;                // Low byte lane was strobed
  logic              next_w_lane0;
  logic              bvalid;                 // Write response pending
  logic              next_bvalid;
  logic [1:0]        bresp;
  logic [1:0]        next_bresp;
  // Read channel state
  logic              rvalid;                 // Read data pending
  logic              next_rvalid;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]        rresp;
  logic [1:0]        next_rresp;
  // Register contents
  logic [23:0]       reload;                 // Reload value, upper/middle/low bytes
  logic [23:0]       next_reload;
  logic [7:0]        reset_cause;            // Cause flags, low nibble never written
  logic [7:0]        next_reset_cause;
  logic [1:0]        int_stat;               // Sticky events
  logic [1:0]        next_int_stat;
  logic [1:0]        int_mask;               // Event enables
  logic [1:0]        next_int_mask;
  // Pins, prescaler, reset request
  logic [1:0]        stop_sync;              // Two-flop synchroniser, [1] is safe
  logic [1:0]        next_stop_sync;
  logic [1:0]        pin_sync;
  logic [1:0]        next_pin_sync;
  logic              stop_last;              // Previous synchronised level
  logic              pin_last;
  logic [7:0]        div_cnt;                // Prescaler
  logic [7:0]        next_div_cnt;
  logic              reset_req;              // Registered system reset request
  // Combinational helpers
  logic              wr_fire;                // Both halves of a write are held
  logic              ar_fire;                // Read address taken this edge
  wdr_sel_t          wr_sel;
  wdr_sel_t          rd_sel;
  logic              stop_rise;
  logic              pin_rise;

  // Handshakes: one write and one read in flight at a time
  assign s_axi_awready_out = !aw_held && !bvalid;
  assign s_axi_wready_out  = !w_held && !bvalid;
  assign s_axi_arready_out = !rvalid;
  assign wr_fire   = aw_held && w_held && !bvalid;
  assign ar_fire   = s_axi_arvalid_in && !rvalid;
  assign wr_sel    = decode(aw_addr);
  assign rd_sel    = decode(s_axi_araddr_in);
  // Edge detectors read only the second synchroniser stage
  assign stop_rise = stop_sync[1] && !stop_last;
  assign pin_rise  = pin_sync[1] && !pin_last;

  // Counter link
  assign cnt_if.tick       = (div_cnt == TICK_DIV - 8'h01);
  assign cnt_if.load       = wr_fire && w_lane0 && (wr_sel == SEL_CTL);
  assign cnt_if.reload_val = reload;

  wdr_counter u_counter (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .bus    (cnt_if)
  );

  // Bus and register next state; event sets come last so they beat clears
  always_comb begin
    next_aw_held     = aw_held;
    next_aw_addr     = aw_addr;
    next_w_held      = w_held;
    next_w_data      = w_data;
    next_w_lane0     = w_lane0;
    next_bvalid      = bvalid;
    next_bresp       = bresp;
    next_rvalid      = rvalid;
    next_rdata       = rdata;
    next_rresp       = rresp;
    next_reload      = reload;
    next_reset_cause = reset_cause;
    next_int_stat    = int_stat;
    next_int_mask    = int_mask;
    // Address and data may arrive in either order
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_w_held  = 1'b1;
      next_w_data  = s_axi_wdata_in[7:0];
      next_w_lane0 = s_axi_wstrb_in[0];
    end
    if (bvalid && s_axi_bready_in) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      // Writes without the low lane strobed change nothing
      if (w_lane0) begin
        case (wr_sel)
          SEL_UPPER:    next_reload[23:16] = w_data;
          SEL_MIDDLE:   next_reload[15:8]  = w_data;
          SEL_LOW:      next_reload[7:0]   = w_data;
          SEL_INT_STAT: next_int_stat      = int_stat & ~w_data[1:0];
          SEL_INT_MASK: next_int_mask      = w_data[1:0];
          default:      next_reload        = reload;
        endcase
      end
    end
    if (rvalid && s_axi_rready_in) begin
      next_rvalid = 1'b0;
    end
    if (ar_fire) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = '0;
      case (rd_sel)
        SEL_CTL: begin
          next_rdata[7:0]  = reset_cause;
          next_reset_cause = 8'h00;          // Read clears the cause flags
        end
        SEL_UPPER:    next_rdata[7:0] = cnt_if.count[23:16];
        SEL_MIDDLE:   next_rdata[7:0] = cnt_if.count[15:8];
        SEL_LOW:      next_rdata[7:0] = cnt_if.count[7:0];
        SEL_INT_STAT: next_rdata[1:0] = int_stat;
        SEL_INT_MASK: next_rdata[1:0] = int_mask;
        default:      next_rresp      = RESP_SLVERR;
      endcase
    end
    if (stop_rise) begin
      next_reset_cause[POS_STOP] = 1'b1;
    end
    if (pin_rise) begin
      next_reset_cause[POS_PIN] = 1'b1;
      next_int_stat[INT_PIN]    = 1'b1;
    end
    if (cnt_if.expire) begin
      next_reset_cause[POS_TIMEOUT] = 1'b1;
      next_int_stat[INT_TIMEOUT]    = 1'b1;
    end
  end

  // Bus and register flip-flops
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_held     <= 1'b0;
      aw_addr     <= '0;
      w_held      <= 1'b0;
      w_data      <= 8'h00;
      w_lane0     <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= RESP_OKAY;
      rvalid      <= 1'b0;
      rdata       <= '0;
      rresp       <= RESP_OKAY;
      reload      <= RELOAD_RST;
      reset_cause <= CAUSE_RST;
      int_stat    <= INT_RST;
      int_mask    <= INT_RST;
    end else begin
      aw_held     <= next_aw_held;
      aw_addr     <= next_aw_addr;
      w_held      <= next_w_held;
      w_data      <= next_w_data;
      w_lane0     <= next_w_lane0;
      bvalid      <= next_bvalid;
      bresp       <= next_bresp;
      rvalid      <= next_rvalid;
      rdata       <= next_rdata;
      rresp       <= next_rresp;
      reload      <= next_reload;
      reset_cause <= next_reset_cause;
      int_stat    <= next_int_stat;
      int_mask    <= next_int_mask;
    end
  end

  // Synchroniser and prescaler next state
  always_comb begin
    next_stop_sync = {stop_sync[0], stop_recovery_in};
    next_pin_sync  = {pin_sync[0], pin_reset_in};
    next_div_cnt   = cnt_if.tick ? 8'h00 : div_cnt + 8'h01;
  end

  // Synchroniser, prescaler and reset request flip-flops
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stop_sync <= 2'h0;
      pin_sync  <= 2'h0;
      stop_last <= 1'b0;
      pin_last  <= 1'b0;
      div_cnt   <= 8'h00;
      reset_req <= 1'b0;
    end else begin
      stop_sync <= next_stop_sync;
      pin_sync  <= next_pin_sync;
      stop_last <= stop_sync[1];
      pin_last  <= pin_sync[1];
      div_cnt   <= next_div_cnt;
      reset_req <= cnt_if.expire;
    end
  end

  // Outputs; the interrupt is a level while any enabled event stands
  assign s_axi_bvalid_out = bvalid;
  assign s_axi_bresp_out  = bresp;
  assign s_axi_rvalid_out = rvalid;
  assign s_axi_rdata_out  = rdata;
  assign s_axi_rresp_out  = rresp;
  assign wd_reset_out     = reset_req;
  assign irq_out          = |(int_stat & int_mask);

  a_ctl_read_status: assert property (@(posedge clk_in) disable iff (rst_in)
    ar_fire && rd_sel == SEL_CTL |=> rdata == {24'h000000, $past(reset_cause)})
    else $error("shared address read did not return cause status");
  a_ctl_refresh: assert property (@(posedge clk_in) disable iff (rst_in)
    cnt_if.load |=> cnt_if.count == $past(reload) && reload == $past(reload))
    else $error("control write did not refresh or changed reload");
  a_cause_reserved: assert property (@(posedge clk_in) disable iff (rst_in)
    ar_fire && rd_sel == SEL_CTL |=> rdata[3:0] == 4'h0 && rdata[31:8] == 24'h000000)
    else $error("reserved cause bits not zero");
  a_count_readback: assert property (@(posedge clk_in) disable iff (rst_in)
    ar_fire && rd_sel == SEL_UPPER |=> rdata[7:0] == $past(cnt_if.count[23:16]))
    else $error("upper byte read did not return live count");
  a_reload_write: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_fire && w_lane0 && wr_sel == SEL_LOW |=> reload[7:0] == $past(w_data))
    else $error("low reload byte not written");
  // outer bytes reset, checked at release
  a_reload_reset: assert property (@(posedge clk_in)
    $past(rst_in) && !rst_in |-> reload[23:16] == 8'h00 && reload[7:0] == 8'h00)
    else $error("upper or low reload byte wrong after reset");
  // middle byte reset, checked at release
  a_middle_reset: assert property (@(posedge clk_in)
    $past(rst_in) && !rst_in |-> reload[15:8] == RELOAD_RST[15:8])
    else $error("middle reload byte wrong after reset");
  a_timeout_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    cnt_if.expire |=> wd_reset_out && reset_cause[POS_TIMEOUT] && int_stat[INT_TIMEOUT])
    else $error("expiry did not raise reset request and timeout flag");

endmodule : wdr_top

// >>> tb/wdr_tb.sv
// Self-checking bench for the watchdog register block
`timescale 1ns/1ns
module testbench;
  import wdr_pkg::*;

  // Clock, reset and pins
  logic              clk_in   = 1'b0;
  logic              rst_in   = 1'b1;
  logic              stop_pin = 1'b0;
  logic              rst_pin  = 1'b0;
  // Bus master drive
  logic [ADDR_W-1:0] awaddr   = '0;
  logic              awvalid  = 1'b0;
  logic [DATA_W-1:0] wdata    = '0;
  logic [3:0]        wstrb    = 4'hF;
  logic              wvalid   = 1'b0;
  logic              bready   = 1'b0;
  logic [ADDR_W-1:0] araddr   = '0;
  logic              arvalid  = 1'b0;
  logic              rready   = 1'b0;
  // Design answers
  logic              awready;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              arready;
  logic [DATA_W-1:0] rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              wd_reset_out;
  logic              irq_out;
  // Bookkeeping
  int                err_count  = 0;
  int                n_compared = 0;
  int                since      = 0;  // Clocks since reset release

  always #25 clk_in = ~clk_in;

  // Counts from reset release so the first expiry can be timed
  always @(posedge clk_in) begin
    since <= rst_in ? 0 : since + 1;
  end

  wdr_top dut (
    .clk_in(clk_in), .rst_in(rst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .stop_recovery_in(stop_pin), .pin_reset_in(rst_pin),
    .wd_reset_out(wd_reset_out), .irq_out(irq_out)
  );

  // Verdict and end of run, reached from every path
  task automatic summarize();
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // One comparison, reported at once when it differs
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // A used-up wait bound counts as a mismatch and closes the run
  task automatic give_up();
    check(32'h0, 32'h1);
    summarize();
  endtask : give_up

  // Write one register; address and data offered together, each released when taken
  task automatic axi_wr(input logic [11:0] idx, input logic [7:0] val, output logic [1:0] resp);
    int   n;
    logic ah;
    logic wh;
    logic done;
    n = 0;
    ah = 1'b1;
    wh = 1'b1;
    done = 1'b0;
    @(posedge clk_in);
    awaddr  <= {idx, 2'h0};
    awvalid <= 1'b1;
    wdata   <= {24'h0, val};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      n++;
      if (ah && awready) begin
        ah = 1'b0;
        awvalid <= 1'b0;
      end
      if (wh && wready) begin
        wh = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        done = 1'b1;
        resp = bresp;
        bready <= 1'b0;
      end
      if (n > 50) give_up();
    end
  endtask : axi_wr

  // Read one register; rready held until the answer is sampled
  task automatic axi_rd(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] resp);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge clk_in);
    araddr  <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
      end
      if (n > 50) give_up();
    end
  endtask : axi_rd

  // Waits for the reset request, then checks that it lasts one cycle
  task automatic wait_expiry(input int limit, output int cyc);
    cyc = 0;
    while (wd_reset_out !== 1'b1) begin
      @(posedge clk_in);
      cyc++;
      if (cyc > limit) give_up();
    end
    @(posedge clk_in);
    check({31'h0, wd_reset_out}, 32'h0);
  endtask : wait_expiry

  // Cause flags after reset, then the default reload timed to expiry
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    int          c;
    axi_rd(IDX_CTL, d, r);
    check(d, 32'h80);
    axi_rd(IDX_CTL, d, r);
    check(d, 32'h00);
    axi_rd(IDX_UPPER, d, r);
    check(d, 32'h00);
    wait_expiry(5000, c);
    // Reload 00_04_00 gives 1025 ticks of 4 clocks
    check({31'h0, since >= 4096 && since <= 4112}, 32'h1);
    axi_rd(IDX_CTL, d, r);
    check(d, 32'h20);
    axi_rd(IDX_INT_STAT, d, r);
    check(d, 32'h01);
    check({31'h0, irq_out}, 32'h0);
  endtask : t_reset

  // Short reload through the low byte, refresh by a control write
  task automatic t_short();
    logic [31:0] d;
    logic [1:0]  r;
    int          c;
    axi_wr(IDX_MIDDLE, 8'h00, r);
    axi_wr(IDX_LOW, 8'h03, r);
    axi_wr(IDX_CTL, 8'hA5, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    wait_expiry(40, c);
    // Count 3 needs four ticks to expire; the first tick lands 1 to 4 clocks
    // after the refresh, and the request follows the expiry by one clock
    check({31'h0, c >= 14 && c <= 17}, 32'h1);
    axi_rd(IDX_CTL, d, r);
    // The control byte A5 written earlier never reads back
    check(d, 32'h20);
  endtask : t_short

  // Bytes assemble into the reload; reads show the live count
  task automatic t_live();
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(IDX_UPPER, 8'h12, r);
    axi_wr(IDX_MIDDLE, 8'h34, r);
    axi_wr(IDX_LOW, 8'h56, r);
    axi_wr(IDX_CTL, 8'h00, r);
    axi_rd(IDX_UPPER, d, r);
    check(d, 32'h12);
    axi_rd(IDX_MIDDLE, d, r);
    check(d, 32'h34);
    axi_rd(IDX_LOW, d, r);
    // Already counted down, so not the stored 56
    check({31'h0, d < 32'h56 && d > 32'h40}, 32'h1);
  endtask : t_live

  // Interrupt unmasked, then cleared by writing one
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(IDX_INT_MASK, 8'h01, r);
    @(posedge clk_in);
    check({31'h0, irq_out}, 32'h1);
    axi_wr(IDX_INT_STAT, 8'h01, r);
    @(posedge clk_in);
    check({31'h0, irq_out}, 32'h0);
    axi_rd(IDX_INT_STAT, d, r);
    check(d, 32'h00);
  endtask : t_irq

  // Stop recovery and external pin flags; reserved bits stay zero
  task automatic t_pins();
    logic [31:0] d;
    logic [1:0]  r;
    // The short reload expired again before its refresh; clear that flag first
    axi_rd(IDX_CTL, d, r);
    @(posedge clk_in);
    rst_pin  <= 1'b1;
    stop_pin <= 1'b1;
    repeat (6) @(posedge clk_in);
    rst_pin  <= 1'b0;
    stop_pin <= 1'b0;
    repeat (3) @(posedge clk_in);
    axi_rd(IDX_CTL, d, r);
    check(d, 32'h50);
    axi_rd(IDX_INT_STAT, d, r);
    check(d, 32'h02);
    check({31'h0, irq_out}, 32'h0);
    axi_wr(IDX_INT_MASK, 8'h03, r);
    @(posedge clk_in);
    check({31'h0, irq_out}, 32'h1);
  endtask : t_pins

  // Unmapped place answers with an error and stores nothing
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(12'h200, 8'h5A, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_rd(12'h200, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    check(d, 32'h00);
    // A write without the low lane strobed must leave the mask alone
    wstrb <= 4'h0;
    axi_wr(IDX_INT_MASK, 8'h00, r);
    wstrb <= 4'hF;
    axi_rd(IDX_INT_MASK, d, r);
    check(d, 32'h03);
  endtask : t_bus

  // Main sequence: reset held for four clocks, then the scenarios
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_short();
    t_live();
    t_irq();
    t_pins();
    t_bus();
    summarize();
  end
endmodule : testbench
